/* File: acv_pkg.sv */
// shared constants and types of the converter control block
package acv_pkg;

  // ******************************************
  // widths and timing
  // ******************************************
  localparam int unsigned RES_W = 12;            // result bits
  localparam int unsigned DATA_W = 16;           // register word width
  localparam int unsigned ADDR_W = 4;            // register address width
  localparam int unsigned CLK_NS = 40;           // sys_clk period in ns
  localparam int unsigned INSTR_NS = 160;        // one instruction cycle in ns
  localparam int unsigned INSTR_CYC = (INSTR_NS + CLK_NS - 1) / CLK_NS; // rounded up

  // ******************************************
  // register offsets
  // ******************************************
  localparam logic [3:0] OFF_CTRL = 4'h0;        // control bits
  localparam logic [3:0] OFF_CDIV = 4'h1;        // conv_clock_divider
  localparam logic [3:0] OFF_STAT = 4'h2;        // flags, write one to clear
  localparam logic [3:0] OFF_RES = 4'h3;         // result_pair
  localparam logic [3:0] OFF_PREV = 4'h4;        // previous_result
  localparam logic [3:0] OFF_ACC = 4'h5;         // accumulator
  localparam logic [3:0] OFF_ERR = 4'h6;         // error_value
  localparam logic [3:0] OFF_SETP = 4'h7;        // setpoint for error
  localparam logic [3:0] OFF_THR = 4'h8;         // threshold limit
  localparam logic [3:0] OFF_TSEL = 4'h9;        // trigger_source_select

  // ******************************************
  // field positions
  // ******************************************
  localparam int unsigned B_ON = 0;              // module on
  localparam int unsigned B_GO = 1;              // conversion go
  localparam int unsigned B_RCSEL = 2;           // 1 = converter_rc_clock
  localparam int unsigned B_JUST = 3;            // result_justify, 1 = right
  localparam int unsigned B_CONTINUOUS_MODE = 4;            // continuous_mode
  localparam int unsigned B_PREVIOUS_SOURCE_SELECT = 5;            // previous_source_select
  localparam int unsigned B_DOUBLE_SAMPLE_ENABLE = 6;            // double_sample_enable
  localparam int unsigned B_IEN = 7;             // conversion_irq_enable
  localparam int unsigned B_DONE = 0;            // conversion_done_flag
  localparam int unsigned B_COMPUTATION_DONE_FLAG = 1;            // computation_done_flag
  localparam int unsigned B_THR = 2;             // threshold_irq_flag
  localparam int unsigned B_BUSY = 3;            // conversion running
  localparam int unsigned B_TEN = 3;             // trigger enable in trigger select

  // ******************************************
  // reset values
  // ******************************************
  localparam logic [5:0] CDIV_RST = 6'h00;       // divide by 2
  localparam logic [15:0] WORD_RST = 16'h0000;   // data registers
  localparam logic [11:0] MSB_ONEHOT = 12'h800;  // first trial bit

  // converter sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONV, ST_COMPUTATION_DONE_FLAG} acv_state_t;

endpackage : acv_pkg

/* File: acv_clk_if.sv */
// conversion clock selection and tick carrier
`timescale 1ns/1ns
`default_nettype none
interface acv_clk_if;
  logic rc_sel;      // 1 selects the rc oscillator
  logic [5:0] div;   // system clock divider code
  logic tick;        // one sys_clk pulse per bit_period
  modport gen (input rc_sel, input div, output tick);
  modport ctl (output rc_sel, output div, input tick);
endinterface : acv_clk_if
`default_nettype wire

/* File: acv_tick_gen.sv */
// bit period tick generator from divided system clock or rc oscillator
`timescale 1ns/1ns
`default_nettype none
module acv_tick_gen
  import acv_pkg::*;
(
  input wire logic sys_clk,    // system clock
  input wire logic sys_rst,    // synchronous reset, high
  input wire logic rc_osc_in,  // dedicated_rc_oscillator pin
  acv_clk_if.gen ck            // selection in, tick out
);

  // ******************************************
  // rc oscillator synchroniser
  // ******************************************
  logic rc_s1_r;   // first stage, read only by second
  logic rc_s2_r;   // second stage
  logic rc_s3_r;   // third stage
  logic rc_lvl_r;  // accepted oscillator level
  logic [5:0] cnt_r; // divider count
  logic ph_r;      // divider half phase
  logic tick_r;    // registered tick

  // a change counts once the last two stages agree
  wire rc_agree = (rc_s2_r == rc_s3_r);
  wire rc_rise = rc_agree && rc_s3_r && !rc_lvl_r;
  wire cnt_end = (cnt_r == ck.div);
  wire div_tick = cnt_end && ph_r;      // period is 2 * (div + 1)
  // a source switch could line up two ticks; never let them touch
  wire tick_nxt = !tick_r && (ck.rc_sel ? rc_rise : div_tick); // RULE1

  // shift the oscillator through three flops
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rc_s1_r <= 1'b0;
      rc_s2_r <= 1'b0;
      rc_s3_r <= 1'b0;
      rc_lvl_r <= 1'b0;
    end
    else
    begin
      rc_s1_r <= rc_osc_in;
      rc_s2_r <= rc_s1_r;
      rc_s3_r <= rc_s2_r;
      if (rc_agree)
        rc_lvl_r <= rc_s3_r;
    end
  end

  // divider: count to div twice per bit period
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || ck.rc_sel)
    begin
      cnt_r <= 6'h00;
      ph_r <= 1'b0;
    end
    else if (cnt_end)
    begin
      cnt_r <= 6'h00; // RULE2
      ph_r <= !ph_r;
    end
    else
      cnt_r <= cnt_r + 6'h01;
  end

  // tick register drives the carrier
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      tick_r <= 1'b0;
    else
      tick_r <= tick_nxt;
  end
  assign ck.tick = tick_r;

  // ******************************************
  // checks
  // ******************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_tick_single: assert property (tick_r |=> !tick_r) // RULE4
    else $error("tick longer than one cycle");
  a_div_two: assert property (
    (!ck.rc_sel && ck.div == 6'h00 && tick_r) ##1 (!ck.rc_sel && ck.div == 6'h00)
    |=> tick_r) // RULE2
    else $error("divide by two period wrong");

endmodule : acv_tick_gen
`default_nettype wire

/* File: acv_conv_ctrl.sv */
// sar converter control: clocking, start, completion, result and computation_done_flag
// What this block does
// RULE1: source bit picks divided or rc clock
// RULE2: divider ratio is two times (code plus one)
// RULE3: control logic steps on conversion clock
// RULE4: one bit decision per bit period
// RULE5: result shown left or right justified
// RULE6: result writes stored right justified always
// RULE7: done flag set after every conversion
// RULE8: software clears done flag itself
// RULE9: irq when done flag and enable
// RULE10: sleep conversions only on rc; wake request
// RULE11: conversions run only while module on
// RULE12: go, trigger edge or continuous retrigger start
// RULE13: software avoids go with module on
// RULE14: copy old result to previous first
// RULE15: completion clears go unless continuous mode
// RULE16: completion sets computation_done_flag flag, updates accumulator
// RULE17: error and threshold per one or two
// RULE18: computation_done_flag runs after result is final
// RULE19: abort loads partial, fill with last bit
// RULE20: computation_done_flag still runs on partial result
// RULE21: reset returns everything, ends conversion
// RULE22: rc start delayed; a sleep conversion with irq disabled powers converter down
// RULE23: non-rc sleep trigger waits for wake
// RULE24: trigger rising edge sets go bit
// RULE25: msb first successive approximation after sampling
`timescale 1ns/1ns
`default_nettype none
module acv_conv_ctrl
  import acv_pkg::*;
#(
  parameter int unsigned TRIG_N = 8  // number of trigger inputs
)
(
  input wire logic sys_clk,               // system clock, 25 MHz
  input wire logic sys_rst,               // synchronous reset, high
  input wire logic [3:0] addr,            // register address
  input wire logic [15:0] wr_data,        // write data
  input wire logic wr_en,                 // write strobe
  input wire logic rd_en,                 // read strobe
  output logic [15:0] rd_data_r,          // read data, cycle after strobe
  input wire logic [TRIG_N-1:0] trig_in,  // external trigger pins
  input wire logic comp_in,               // comparator: input above trial
  input wire logic rc_osc_in,             // dedicated rc oscillator
  input wire logic sleep_in,              // device is in sleep
  output logic [11:0] dac_code_r,         // trial code to the analog side
  output logic sample_r,                  // sampler tracking input
  output logic conv_pwr_r,                // converter powered
  output logic irq_r,                     // conversion interrupt request
  output logic wake_r                     // wake request from sleep
);

  // ******************************************
  // control and data registers
  // ******************************************
  logic on_r, go_r, rc_sel_r, just_r;     // control bits
  logic continuous_mode_r, previous_source_select_r, double_sample_enable_r, ien_r;    // control bits
  logic [5:0] div_r;                      // divider code
  logic done_r, computation_done_flag_r, thr_r;            // sticky flags
  logic [11:0] result_r;                  // right justified result
  logic [11:0] prev_r;                    // previous result
  logic [15:0] acc_r;                     // running sum of results
  logic [15:0] err_r;                     // last error value
  logic [15:0] setp_r;                    // setpoint
  logic [15:0] lim_r;                     // threshold limit
  logic [2:0] tsel_r;                     // trigger input index
  logic ten_r;                            // trigger enable
  logic pair_r;                           // odd conversion of a pair
  logic pwr_dn_r;                         // powered down after sleep conversion
  acv_state_t st_r;                       // sequencer state
  logic [2:0] dly_r;                      // rc start delay count
  logic [11:0] sar_r;                     // decided bits
  logic [11:0] mask_r;                    // one-hot trial bit
  logic lastb_r;                          // last decided bit
  logic [11:0] fin_r;                     // final value kept for computation_done_flag
  logic trig_prev_r;                      // trigger level last cycle

  // ******************************************
  // pin synchronisers
  // ******************************************
  localparam int unsigned EXT_N = TRIG_N + 1;
  wire [EXT_N-1:0] ext_in = {comp_in, trig_in};
  logic [EXT_N-1:0] ext_lvl;             // accepted levels

  // three flops per pin, accept when the last two agree
  generate
    for (genvar i = 0; i < EXT_N; i++)
    begin : g_sync
      logic s1_r, s2_r, s3_r, lvl_r;
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          lvl_r <= 1'b0;
        end
        else
        begin
          s1_r <= ext_in[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
            lvl_r <= s3_r;
        end
      end
      assign ext_lvl[i] = lvl_r;
    end
  endgenerate

  // comparator settles through the sync, so keep bit_period above
  // four sys_clk cycles; divider codes 0 and 1 are too fast for it
  wire comp_q = ext_lvl[TRIG_N];
  wire trig_lvl = ext_lvl[tsel_r];

  // ******************************************
  // conversion clock
  // ******************************************
  acv_clk_if ck ();
  assign ck.rc_sel = rc_sel_r; // RULE1
  assign ck.div = div_r;
  wire tick = ck.tick;

  acv_tick_gen u_tick (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .rc_osc_in (rc_osc_in),
    .ck (ck.gen)
  );

  // ******************************************
  // decoding
  // ******************************************
  wire wr_ctrl = wr_en && (addr == OFF_CTRL);
  wire wr_cdiv = wr_en && (addr == OFF_CDIV);
  wire wr_stat = wr_en && (addr == OFF_STAT);
  wire wr_res = wr_en && (addr == OFF_RES);
  wire wr_setp = wr_en && (addr == OFF_SETP);
  wire wr_thr = wr_en && (addr == OFF_THR);
  wire wr_tsel = wr_en && (addr == OFF_TSEL);

  // ******************************************
  // sequencer decisions
  // ******************************************
  wire trig_evt = ten_r && trig_lvl && !trig_prev_r;    // RULE24
  wire busy = (st_r == ST_SAMPLE) || (st_r == ST_CONV);
  // a non-rc start waits out sleep; powered down waits too
  wire may_run = on_r && !pwr_dn_r && (!sleep_in || rc_sel_r); // RULE10 RULE23
  wire start = (st_r == ST_IDLE) && go_r && may_run;  // RULE11 RULE12
  wire dly_end = (dly_r == 3'(INSTR_CYC - 1));
  wire off_stop = tick && busy && !on_r;
  wire abort = tick && busy && on_r && !go_r;         // RULE3 RULE19
  wire last_bit = tick && (st_r == ST_CONV) && mask_r[0] && go_r && on_r;
  wire done_evt = last_bit || abort;
  wire [11:0] undec = mask_r | (mask_r - 12'h001);
  wire [11:0] sar_dec = sar_r | (comp_q ? mask_r : 12'h000); // RULE25
  wire [11:0] partial = (sar_r & ~undec) | (lastb_r ? undec : 12'h000); // RULE19
  wire [11:0] fin_nxt = abort ? partial : sar_dec;
  wire do_computation_done_flag = !double_sample_enable_r || !pair_r;                // RULE17
  wire [15:0] err_nxt = {4'h0, fin_r} - setp_r;
  wire thr_hit = $signed(err_nxt) > $signed(lim_r);
  wire [15:0] res_view = just_r ? {4'h0, result_r} : {result_r, 4'h0}; // RULE5 RULE6
  wire [11:0] dac_nxt = (st_r == ST_CONV) ? (sar_r | mask_r) : sar_r;

  // read selection, unmapped reads give zero
  wire [15:0] ctrl_view = {8'h00, ien_r, double_sample_enable_r, previous_source_select_r, continuous_mode_r,
                           just_r, rc_sel_r, go_r, on_r};
  wire [15:0] stat_view = {12'h000, busy, thr_r, computation_done_flag_r, done_r};
  wire [15:0] rd_nxt =
    (addr == OFF_CTRL) ? ctrl_view :
    (addr == OFF_CDIV) ? {10'h000, div_r} :
    (addr == OFF_STAT) ? stat_view :
    (addr == OFF_RES) ? res_view :
    (addr == OFF_PREV) ? {4'h0, prev_r} :
    (addr == OFF_ACC) ? acc_r :
    (addr == OFF_ERR) ? err_r :
    (addr == OFF_SETP) ? setp_r :
    (addr == OFF_THR) ? lim_r :
    (addr == OFF_TSEL) ? {12'h000, ten_r, tsel_r} : WORD_RST;

  // ******************************************
  // control register
  // ******************************************
  // plain control bits; all return to reset values here
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst) // RULE21
    begin
      {on_r, rc_sel_r, just_r, continuous_mode_r, previous_source_select_r, double_sample_enable_r, ien_r} <= 7'h00;
      div_r <= CDIV_RST;
      setp_r <= WORD_RST;
      lim_r <= WORD_RST;
      {ten_r, tsel_r} <= 4'h0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        on_r <= wr_data[B_ON];
        rc_sel_r <= wr_data[B_RCSEL];
        just_r <= wr_data[B_JUST];
        continuous_mode_r <= wr_data[B_CONTINUOUS_MODE];
        previous_source_select_r <= wr_data[B_PREVIOUS_SOURCE_SELECT];
        double_sample_enable_r <= wr_data[B_DOUBLE_SAMPLE_ENABLE];
        ien_r <= wr_data[B_IEN];
      end
      if (wr_cdiv)
        div_r <= wr_data[5:0];
      if (wr_setp)
        setp_r <= wr_data;
      if (wr_thr)
        lim_r <= wr_data;
      if (wr_tsel)
        {ten_r, tsel_r} <= wr_data[3:0];
    end
  end

  // go bit: hardware set outranks every clear
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      go_r <= 1'b0;
    else if (trig_evt)
      go_r <= 1'b1;                 // RULE24
    else if (wr_ctrl)
      go_r <= wr_data[B_GO];        // RULE12
    else if (done_evt && !continuous_mode_r)
      go_r <= 1'b0;                 // RULE15
  end

  // sticky flags, write one to clear, a set in the same cycle wins
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      done_r <= 1'b0;
      computation_done_flag_r <= 1'b0;
      thr_r <= 1'b0;
    end
    else
    begin
      done_r <= done_evt || (done_r && !(wr_stat && wr_data[B_DONE])); // RULE7 RULE8
      computation_done_flag_r <= done_evt || (computation_done_flag_r && !(wr_stat && wr_data[B_COMPUTATION_DONE_FLAG])); // RULE16
      thr_r <= (st_r == ST_COMPUTATION_DONE_FLAG && do_computation_done_flag && thr_hit)
               || (thr_r && !(wr_stat && wr_data[B_THR]));              // RULE17
    end
  end

  // ******************************************
  // sequencer
  // ******************************************
  // sampling and bit steps move only on the conversion clock tick
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      st_r <= ST_IDLE;
    else
    begin
      unique case (st_r)
        ST_IDLE:
          if (start)
            st_r <= rc_sel_r ? ST_DELAY : ST_SAMPLE; // RULE22
        ST_DELAY:
          if (!on_r)
            st_r <= ST_IDLE;
          else if (dly_end)
            st_r <= ST_SAMPLE;
        ST_SAMPLE:
          if (off_stop)
            st_r <= ST_IDLE;                // RULE11
          else if (abort)
            st_r <= ST_COMPUTATION_DONE_FLAG;                // RULE20
          else if (tick)
            st_r <= ST_CONV;                // RULE25
        ST_CONV:
          if (off_stop)
            st_r <= ST_IDLE;
          else if (done_evt)
            st_r <= ST_COMPUTATION_DONE_FLAG;                // RULE18
        ST_COMPUTATION_DONE_FLAG:
          st_r <= ST_IDLE;                  // continuous mode restarts from idle
      endcase
    end
  end

  // rc start delay counter
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || st_r != ST_DELAY)
      dly_r <= 3'h0;
    else
      dly_r <= dly_r + 3'h1;
  end

  // successive approximation, one decision per tick
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || start)
    begin
      sar_r <= 12'h000;
      mask_r <= MSB_ONEHOT;
      lastb_r <= 1'b0;
    end
    else if (tick && st_r == ST_CONV && !done_evt)
    begin
      sar_r <= sar_dec;                     // RULE4
      lastb_r <= comp_q;
      mask_r <= mask_r >> 1;
    end
  end

  // ******************************************
  // completion side effects
  // ******************************************
  // previous copy takes the old value before the new one lands
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      result_r <= 12'h000;
      prev_r <= 12'h000;
      acc_r <= WORD_RST;
      fin_r <= 12'h000;
      pair_r <= 1'b0;
    end
    else if (done_evt)
    begin
      if (previous_source_select_r)
        prev_r <= result_r;                 // RULE14
      result_r <= fin_nxt;
      fin_r <= fin_nxt;
      acc_r <= acc_r + {4'h0, fin_nxt};     // RULE16
      pair_r <= !pair_r;
    end
    else if (wr_res)
      result_r <= wr_data[11:0];            // RULE6
  end

  // error value computed one cycle after the result is final
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      err_r <= WORD_RST;
    else if (st_r == ST_COMPUTATION_DONE_FLAG && do_computation_done_flag)
      err_r <= err_nxt;                     // RULE17 RULE20
  end

  // ******************************************
  // outputs
  // ******************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      trig_prev_r <= 1'b0;
      pwr_dn_r <= 1'b0;
      rd_data_r <= WORD_RST;
      dac_code_r <= 12'h000;
      sample_r <= 1'b0;
      conv_pwr_r <= 1'b0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end
    else
    begin
      trig_prev_r <= trig_lvl;
      if (done_evt && sleep_in && !ien_r)
        pwr_dn_r <= 1'b1;                   // RULE22
      else if (!sleep_in)
        pwr_dn_r <= 1'b0;
      rd_data_r <= rd_en ? rd_nxt : WORD_RST;
      dac_code_r <= dac_nxt;
      sample_r <= (st_r == ST_SAMPLE);
      conv_pwr_r <= on_r && !pwr_dn_r;
      irq_r <= done_r && ien_r;             // RULE9
      wake_r <= done_r && ien_r && sleep_in; // RULE10
    end
  end

  // ******************************************
  // checks
  // ******************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_rc_start;
    (st_r == ST_IDLE) && start && rc_sel_r;
  endsequence
  sequence s_delay_hold;
    (st_r == ST_DELAY && on_r) [*4];
  endsequence

  a_done_flag_set: assert property (done_evt |=> done_r) // RULE7
    else $error("done flag not set at completion");
  a_irq_follow: assert property (done_r && ien_r |=> irq_r ##1 (irq_r || !done_r)) // RULE9
    else $error("interrupt request missing");
  a_go_cleared: assert property (
    done_evt && !continuous_mode_r && !trig_evt && !wr_ctrl |=> !go_r) // RULE15
    else $error("go not cleared at completion");
  a_continuous_mode_keeps_go: assert property (
    done_evt && continuous_mode_r && go_r && !wr_ctrl |=> go_r) // RULE15
    else $error("go dropped in continuous mode");
  a_prev_copy: assert property (done_evt && previous_source_select_r |=> prev_r == $past(result_r)) // RULE14
    else $error("previous result not copied");
  a_computation_done_flag_after: assert property (done_evt |=> computation_done_flag_r && st_r == ST_COMPUTATION_DONE_FLAG) // RULE16
    else $error("computation_done_flag step not after completion");
  a_off_idle: assert property (st_r == ST_IDLE && !on_r |=> st_r == ST_IDLE) // RULE11
    else $error("conversion started while off");
  a_sleep_wait: assert property (
    st_r == ST_IDLE && sleep_in && !rc_sel_r |=> st_r == ST_IDLE) // RULE23
    else $error("non-rc conversion started in sleep");
  a_rc_delay: assert property (s_rc_start ##1 s_delay_hold |=> st_r != ST_DELAY) // RULE22
    else $error("rc start delay length wrong");
  a_trig_go: assert property (trig_evt |=> go_r) // RULE24
    else $error("trigger edge did not set go");
  a_left_just: assert property (
    rd_en && addr == OFF_RES && !just_r |=> rd_data_r[3:0] == 4'h0) // RULE5
    else $error("left justified read has low bits");
  a_abort_fill: assert property (abort |=> result_r == $past(partial)) // RULE19
    else $error("partial result wrong after abort");

endmodule : acv_conv_ctrl
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import acv_pkg::*;
  // ****************
  // stimulus and wires
  // ****************
  logic sys_clk = 1'b0; // 25 MHz system clock
  logic sys_rst = 1'b1; // held two cycles
  logic [3:0] addr = 4'h0;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] trig_in = 8'h00;
  logic comp_in = 1'b1; // high keeps every trial bit
  logic rc_osc_in = 1'b0; // free running rc pin
  logic sleep_in = 1'b0;
  wire logic [15:0] rd_data_r;
  wire logic [11:0] dac_code_r;
  wire logic sample_r;
  wire logic conv_pwr_r;
  wire logic irq_r;
  wire logic wake_r;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  logic [15:0] rv; // last read word
  localparam logic [15:0] C_BASE = 16'h00a9; // on, right, prev copy, irq enable
  acv_conv_ctrl i_acv_conv_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_r(rd_data_r),
    .trig_in(trig_in), .comp_in(comp_in), .rc_osc_in(rc_osc_in), .sleep_in(sleep_in),
    .dac_code_r(dac_code_r), .sample_r(sample_r), .conv_pwr_r(conv_pwr_r),
    .irq_r(irq_r), .wake_r(wake_r));
  always #20 sys_clk = ~sys_clk;
  // rc pin toggles off the clock edges; each level spans two or three samples
  initial
  begin
    #5;
    forever #90 rc_osc_in = ~rc_osc_in;
  end
  // hang guard: far above the longest test
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  // ****************
  // bus tasks
  // ****************
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 rv = rd_data_r;
  endtask : rd
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one read followed by its compare
  task automatic rdc(input logic [3:0] a, input string nm, input logic [15:0] e);
    rd(a);
    chk(nm, e, rv);
  endtask : rdc
  // poll the done flag under a bounded count
  task automatic wait_done();
    rv = 16'h0000;
    for (int i = 0; i < 150 && rv[B_DONE] !== 1'b1; i++) rd(OFF_STAT);
    chk("done", 16'h0001, {15'h0, rv[B_DONE]});
  endtask : wait_done
  task automatic print_verdict();
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  // ****************
  // main sequence
  // ****************
  initial
  begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdc(OFF_CTRL, "ctrl rst", 16'h0000);
    rdc(OFF_CDIV, "cdiv rst", 16'h0000);
    rdc(4'hb, "unmapped", 16'h0000);
    wr(OFF_CDIV, 16'h0002);
    // module on first, go only in a later write
    wr(OFF_CTRL, C_BASE);
    wr(OFF_CTRL, C_BASE | 16'h0002);
    // second trial code must hold exactly one bit period
    n = 0;
    while (dac_code_r !== 12'hc00 && n < 300)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    n = 0;
    while (dac_code_r === 12'hc00 && n < 300)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("bit period", 16'h0006, n[15:0]);
    wait_done();
    rdc(OFF_RES, "res right", 16'h0fff);
    rdc(OFF_STAT, "stat", 16'h0007);
    rdc(OFF_CTRL, "go clr", C_BASE);
    chk("irq", 16'h0001, {15'h0, irq_r});
    chk("pwr on", 16'h0001, {15'h0, conv_pwr_r});
    wr(OFF_CTRL, 16'h00a1);
    rdc(OFF_RES, "res left", 16'hfff0);
    wr(OFF_RES, 16'h0123);
    rdc(OFF_RES, "res wr", 16'h1230);
    wr(OFF_STAT, 16'h0007);
    rdc(OFF_STAT, "stat clr", 16'h0000);
    comp_in <= 1'b0;
    wr(OFF_CTRL, 16'h00a3);
    wait_done();
    rdc(OFF_PREV, "prev", 16'h0123);
    rdc(OFF_ACC, "acc", 16'h0fff);
    rdc(OFF_STAT, "stat2", 16'h0003);
    wr(OFF_STAT, 16'h0007);
    // module off: go alone starts nothing
    wr(OFF_CTRL, 16'h0002);
    repeat (100) @(posedge sys_clk);
    rdc(OFF_STAT, "off", 16'h0000);
    chk("pwr off", 16'h0000, {15'h0, conv_pwr_r});
    wr(OFF_CTRL, C_BASE);
    wr(OFF_TSEL, 16'h000a);
    trig_in <= 8'h04;
    wait_done();
    trig_in <= 8'h00;
    wr(OFF_TSEL, 16'h0000);
    wr(OFF_STAT, 16'h0007);
    sleep_in <= 1'b1;
    wr(OFF_CTRL, C_BASE | 16'h0006);
    wait_done();
    chk("wake", 16'h0001, {15'h0, wake_r});
    sleep_in <= 1'b0;
    // leaving rc restarts the divider, so the first tick comes late in sampling
    comp_in <= 1'b1;
    wr(OFF_SETP, 16'h0001);
    wr(OFF_STAT, 16'h0007);
    wr(OFF_CTRL, C_BASE | 16'h0002);
    wr(OFF_CTRL, C_BASE);
    #1 chk("sampling", 16'h0001, {15'h0, sample_r});
    wait_done();
    rdc(OFF_RES, "abort res", 16'h0000);
    rdc(OFF_ERR, "abort err", 16'hffff);
    // continuous mode with double sampling keeps go and computes on pairs
    wr(OFF_STAT, 16'h0007);
    wr(OFF_CTRL, 16'h00fb);
    wait_done();
    rdc(OFF_CTRL, "go kept", 16'h00fb);
    rdc(OFF_ERR, "pair err", 16'h0ffe);
    wr(OFF_CTRL, C_BASE);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
